// *** shared/event_pkg.sv ***
// constants for the system interrupt status and enable block
//----------------------------------------------------------------------
// Behaviour
// - status flags show their source regardless of enable bits
// - writing one clears a write-one-to-clear flag, zero leaves it
// - soft event flag at bit 31 sets while its enable is high
// - ready flag at bit 30 sets once device accessible after reset
// - bit 28 mirrors fabric pending event, read only
// - bits 27 and 26 mirror port two and port one phy events
// - timer flag bit 19 sets when timer wraps past zero to FFFFh
// - bit 12 mirrors the pin bank cascaded event, read only
// - status register at offset 058h reports met conditions as one
// - set enable bit lets its source drive the interrupt request
// - enable register at 05Ch mirrors status bit positions
// - all enable bits zero after reset
// - master line active when any flag and its enable are set
// - global output enable gates master line onto request pin only
//----------------------------------------------------------------------
package event_pkg;

    localparam logic [11:0] STATUS_OFFSET = 12'h058;
    localparam logic [11:0] ENABLE_OFFSET = 12'h05C;
    localparam logic [11:0] CONTROL_OFFSET = 12'h054;

    localparam int SOFT_BIT   = 31;
    localparam int READY_BIT  = 30;
    localparam int FABRIC_BIT = 28;
    localparam int PHY2_BIT   = 27;
    localparam int PHY1_BIT   = 26;
    localparam int TIMER_BIT  = 19;
    localparam int PIN_BIT    = 12;
    localparam int OUT_EN_BIT = 8;
    localparam int MASTER_BIT = 12;

    localparam logic [31:0] IMPL_MASK    = 32'hDC08_1000;
    localparam logic [31:0] STICKY_MASK  = 32'hC008_0000;
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
    localparam logic [15:0] TIMER_WRAP   = 16'hFFFF;

endpackage : event_pkg

// *** verilog/event_flag.sv ***
// one write-one-to-clear sticky flag
module event_flag
    import event_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    input  wire logic setEvent,
    input  wire logic clearReq,
    output logic      flag
);

    typedef struct packed {
        logic flag;
    } state_s;

    state_s state;
    state_s next_state;

    always_comb
    begin
        next_state = state;
        if (clkEn)
        begin
            // set wins over a same-cycle clear
            if (setEvent)
                next_state.flag = 1'b1;
            else if (clearReq)
                next_state.flag = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            state <= '0;
        else
            state <= next_state;
    end

    assign flag = state.flag;

endmodule : event_flag

// *** verilog/wrap_detect.sv ***
// detects the general purpose timer wrapping from zero to its reload value
module wrap_detect
    import event_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    input  wire logic [15:0] timerCount,
    output logic             wrapPulse
);

    typedef struct packed {
        logic [15:0] lastCount;
        logic        primed;
    } state_s;

    state_s state;
    state_s next_state;

    always_comb
    begin
        next_state = state;
        if (clkEn)
        begin
            next_state.lastCount = timerCount;
            next_state.primed    = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            state <= '0;
        else
            state <= next_state;
    end

    // zero followed by FFFFh is a wrap
    assign wrapPulse = clkEn && state.primed && (state.lastCount == 16'h0000)
                       && (timerCount == TIMER_WRAP);

endmodule : wrap_detect

// *** verilog/system_interrupt_status_enable.sv ***
// system interrupt status, enable and request output logic
module system_interrupt_status_enable
    import event_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    input  wire logic [11:0] regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [31:0] regRdData,
    input  wire logic        deviceReady,
    input  wire logic        fabricPending,
    input  wire logic        portTwoPhyEvent,
    input  wire logic        portOnePhyEvent,
    input  wire logic        pinBankEvent,
    input  wire logic [15:0] timerCountValue,
    output logic             irqOut,
    output logic             masterIrq
);

    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] enable;
        logic        outEnable;
        logic        readySeen;
        logic [31:0] rdData;
        logic        irq;
    } state_s;

    state_s state;
    state_s next_state;

    logic        softFlag;
    logic        readyFlag;
    logic        timerFlag;
    logic        timerWrap;
    logic        readyPulse;
    logic [31:0] statusWord;
    logic [31:0] clearBits;
    logic        anyActive;

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] offs);
        hit = (addr == offs);
    endfunction : hit

    //------------------------------------------------------------------
    // write decode and flags
    //------------------------------------------------------------------
    assign clearBits  = (regWrite && hit(regAddr, STATUS_OFFSET))
                        ? (regWrData & STICKY_MASK) : 32'h0000_0000;
    assign readyPulse = deviceReady && !state.readySeen;

    event_flag softFlagInst (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .setEvent (state.enable[SOFT_BIT]),
        .clearReq (clearBits[SOFT_BIT]),
        .flag     (softFlag)
    );

    event_flag readyFlagInst (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .setEvent (readyPulse),
        .clearReq (clearBits[READY_BIT]),
        .flag     (readyFlag)
    );

    wrap_detect wrapInst (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .clkEn      (clkEn),
        .timerCount (timerCountValue),
        .wrapPulse  (timerWrap)
    );

    event_flag timerFlagInst (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .setEvent (timerWrap),
        .clearReq (clearBits[TIMER_BIT]),
        .flag     (timerFlag)
    );

    //------------------------------------------------------------------
    // status word
    //------------------------------------------------------------------
    always_comb
    begin
        statusWord             = 32'h0000_0000;
        statusWord[SOFT_BIT]   = softFlag;
        statusWord[READY_BIT]  = readyFlag;
        statusWord[FABRIC_BIT] = fabricPending;
        statusWord[PHY2_BIT]   = portTwoPhyEvent;
        statusWord[PHY1_BIT]   = portOnePhyEvent;
        statusWord[TIMER_BIT]  = timerFlag;
        statusWord[PIN_BIT]    = pinBankEvent;
    end

    assign anyActive = |(statusWord & state.enable);

    //------------------------------------------------------------------
    // next state
    //------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        if (clkEn)
        begin
            if (deviceReady)
                next_state.readySeen = 1'b1;
            if (regWrite && hit(regAddr, ENABLE_OFFSET))
                next_state.enable = regWrData & IMPL_MASK;
            if (regWrite && hit(regAddr, CONTROL_OFFSET))
                next_state.outEnable = regWrData[OUT_EN_BIT];
            next_state.rdData = 32'h0000_0000;
            if (regRead)
            begin
                if (hit(regAddr, STATUS_OFFSET))
                    next_state.rdData = statusWord;
                else if (hit(regAddr, ENABLE_OFFSET))
                    next_state.rdData = state.enable;
                else if (hit(regAddr, CONTROL_OFFSET))
                begin
                    next_state.rdData[OUT_EN_BIT] = state.outEnable;
                    next_state.rdData[MASTER_BIT] = anyActive;
                end
            end
            next_state.irq = anyActive;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state        <= '0;
            state.enable <= ENABLE_RESET;
        end
        else
            state <= next_state;
    end

    //------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------
    assign regRdData = state.rdData;
    assign masterIrq = state.irq;
    assign irqOut    = state.irq && state.outEnable;

endmodule : system_interrupt_status_enable

// *** testbench/irq_status_asserts.sv ***
// assertion checker for the interrupt status and enable block
module irq_status_asserts
    import event_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        clkEn,
    input wire logic [11:0] regAddr,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdData,
    input wire logic        fabricPending,
    input wire logic        portOnePhyEvent,
    input wire logic        pinBankEvent,
    input wire logic        irqOut,
    input wire logic        masterIrq
);
    //------------------------------------------
    // helpers and properties
    //------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    logic rdS;
    logic rdE;
    logic rdX;
    logic enTouched;
    assign rdS = regRead && clkEn && regAddr == STATUS_OFFSET;
    assign rdE = regRead && clkEn && regAddr == ENABLE_OFFSET;
    assign rdX = regRead && clkEn && !(regAddr inside
        {STATUS_OFFSET, ENABLE_OFFSET, CONTROL_OFFSET});
    // no enable written yet since reset
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            enTouched <= 1'b0;
        else if (clkEn && regWrite && regAddr == ENABLE_OFFSET)
            enTouched <= 1'b1;
    end
    irq_gate_a: assert property (irqOut |-> masterIrq)
        else $error("irqOut high while masterIrq low");
    quiet_reset_a: assert property (!enTouched |-> !masterIrq)
        else $error("masterIrq before any enable");
    rd_idle_a: assert property (clkEn && !regRead |=> regRdData == 32'h0)
        else $error("read data not zero outside read");
    sts_resv_a: assert property (rdS |=> (regRdData & ~IMPL_MASK) == 32'h0)
        else $error("status reserved bit set");
    en_resv_a: assert property (rdE |=> (regRdData & ~IMPL_MASK) == 32'h0)
        else $error("enable reserved bit set");
    en_zero_a: assert property (rdE && !enTouched |=> regRdData == 32'h0)
        else $error("enable not zero before first write");
    unmapped_a: assert property (rdX |=> regRdData == 32'h0)
        else $error("unmapped read not zero");
    fabric_mirror_a: assert property (rdS && $stable(fabricPending)
        |=> regRdData[FABRIC_BIT] == $past(fabricPending)) else $error("fabric bit wrong");
    phy_mirror_a: assert property (rdS && $stable(portOnePhyEvent)
        |=> regRdData[PHY1_BIT] == $past(portOnePhyEvent)) else $error("phy bit wrong");
    pin_mirror_a: assert property (rdS && $stable(pinBankEvent)
        |=> regRdData[PIN_BIT] == $past(pinBankEvent)) else $error("pin bit wrong");
    cover property (rdS);
    cover property ($rose(irqOut));
    cover property (rdS ##1 regRdData[SOFT_BIT]);
endmodule : irq_status_asserts

bind system_interrupt_status_enable irq_status_asserts irq_status_asserts_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .fabricPending(fabricPending), .portOnePhyEvent(portOnePhyEvent),
    .pinBankEvent(pinBankEvent), .irqOut(irqOut), .masterIrq(masterIrq));

// *** testbench/tb_top.sv ***
// self-checking bench for the interrupt status and enable block
module tb_top import event_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    //------------------------------------------
    // signals, tasks, sequence
    //------------------------------------------
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clkEn = 1'b1;
    logic [11:0] regAddr = 12'h000;
    logic [31:0] regWrData = 32'h0;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic        deviceReady = 1'b0;
    logic        fabricPending = 1'b0;
    logic        portTwoPhyEvent = 1'b0;
    logic        portOnePhyEvent = 1'b0;
    logic        pinBankEvent = 1'b0;
    logic [15:0] timerCountValue = 16'h1234;
    logic [31:0] regRdData;
    logic        irqOut;
    logic        masterIrq;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          srcBit [4] = '{FABRIC_BIT, PHY2_BIT, PHY1_BIT, PIN_BIT};
    system_interrupt_status_enable system_interrupt_status_enable_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .deviceReady(deviceReady), .fabricPending(fabricPending),
        .portTwoPhyEvent(portTwoPhyEvent), .portOnePhyEvent(portOnePhyEvent),
        .pinBankEvent(pinBankEvent), .timerCountValue(timerCountValue),
        .irqOut(irqOut), .masterIrq(masterIrq));
    always #10 clk_sys = ~clk_sys;
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1;
        chk("regRdData", e, regRdData);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : idle
    task automatic flags(input logic m, input logic q);
        #1;
        chk("masterIrq", {31'h0, m}, {31'h0, masterIrq});
        chk("irqOut", {31'h0, q}, {31'h0, irqOut});
    endtask : flags
    task automatic set_src(input int k, input logic v);
        case (k)
            0: fabricPending <= v;
            1: portTwoPhyEvent <= v;
            2: portOnePhyEvent <= v;
            default: pinBankEvent <= v;
        endcase
    endtask : set_src
    initial
    begin
        #200us;
        fail_count++;
        conclude();
    end
    initial
    begin
        idle(20);
        sys_rst <= 1'b0;
        rd(STATUS_OFFSET, 32'h0);
        rd(ENABLE_OFFSET, ENABLE_RESET);
        @(posedge clk_sys) deviceReady <= 1'b1;
        idle(3);
        rd(STATUS_OFFSET, 32'h4000_0000);
        wr(STATUS_OFFSET, 32'h0);
        rd(STATUS_OFFSET, 32'h4000_0000);
        wr(STATUS_OFFSET, 32'h4000_0000);
        rd(STATUS_OFFSET, 32'h0);
        foreach (srcBit[k])
        begin
            @(posedge clk_sys) set_src(k, 1'b1);
            idle(2);
            wr(STATUS_OFFSET, 32'hFFFF_FFFF);
            rd(STATUS_OFFSET, 32'h1 << srcBit[k]);
            flags(1'b0, 1'b0);
            @(posedge clk_sys) set_src(k, 1'b0);
            idle(2);
            rd(STATUS_OFFSET, 32'h0);
        end
        @(posedge clk_sys) timerCountValue <= 16'h0001;
        @(posedge clk_sys) timerCountValue <= TIMER_WRAP;
        idle(2);
        rd(STATUS_OFFSET, 32'h0);
        @(posedge clk_sys) timerCountValue <= 16'h0000;
        @(posedge clk_sys) timerCountValue <= TIMER_WRAP;
        idle(2);
        rd(STATUS_OFFSET, 32'h0008_0000);
        wr(STATUS_OFFSET, 32'h0008_0000);
        rd(STATUS_OFFSET, 32'h0);
        wr(ENABLE_OFFSET, 32'hFFFF_FFFF);
        rd(ENABLE_OFFSET, IMPL_MASK);
        idle(2);
        flags(1'b1, 1'b0);
        rd(STATUS_OFFSET, 32'h8000_0000);
        wr(CONTROL_OFFSET, 32'h0000_0100);
        idle(2);
        flags(1'b1, 1'b1);
        wr(ENABLE_OFFSET, 32'h1000_0000);
        wr(STATUS_OFFSET, 32'h8000_0000);
        idle(2);
        flags(1'b0, 1'b0);
        rd(STATUS_OFFSET, 32'h0);
        @(posedge clk_sys) fabricPending <= 1'b1;
        idle(3);
        flags(1'b1, 1'b1);
        @(posedge clk_sys) fabricPending <= 1'b0;
        idle(3);
        flags(1'b0, 1'b0);
        // mid-run reset with the device still ready
        @(posedge clk_sys) sys_rst <= 1'b1;
        idle(2);
        sys_rst <= 1'b0;
        rd(ENABLE_OFFSET, ENABLE_RESET);
        idle(2);
        rd(STATUS_OFFSET, 32'h4000_0000);
        flags(1'b0, 1'b0);
        // a write while the clock enable is low must be lost
        @(posedge clk_sys) clkEn <= 1'b0;
        wr(ENABLE_OFFSET, 32'h0008_0000);
        @(posedge clk_sys) clkEn <= 1'b1;
        rd(ENABLE_OFFSET, ENABLE_RESET);
        wr(12'h100, 32'hFFFF_FFFF);
        rd(12'h100, 32'h0);
        conclude();
    end
endmodule : tb_top
